// File: testbench.sv
// bench for ucr_ctrl with an upstream host model
`timescale 1ns/1ns
`default_nettype none
`include "ucr_consts.svh"
module testbench;
  localparam int unsigned IDLE = 20;  // shortened counts
  localparam int unsigned SMAX = 200;
  localparam int unsigned RWW  = 40;
  localparam int unsigned DRV  = 30;
  // apb side
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  // line, wake and system pins
  logic        usb_line_idle, usb_line_se0, remote_wake_feature, external_wake_input;
  logic        dp_pullup_out, dp_pullup_oe, usb_resume_out, usb_resume_oe, cpu_irq;
  logic        reset_out, cpu_reset_out, boot_map_normal, clk_enable_out;
  logic        feature_en, saw_rst, mon_clr;
  logic [1:0]  line_mode;
  int          num_errors, checked, res_cyc;
  ucr_ctrl #(.IDLE_CYC(IDLE), .SUSP_MAX_CYC(SMAX), .RW_WAIT_CYC(RWW),
    .RW_DRIVE_CYC(DRV)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .usb_line_idle, .usb_line_se0,
    .remote_wake_feature, .external_wake_input, .dp_pullup_out, .dp_pullup_oe,
    .usb_resume_out, .usb_resume_oe, .reset_out, .cpu_reset_out, .boot_map_normal,
    .clk_enable_out, .cpu_irq);
  ucr_host_model host (.pclk, .presetn, .line_mode, .feature_en, .usb_line_idle,
    .usb_line_se0, .remote_wake_feature);
  // 25 mhz clock
  always #20 pclk = ~pclk;
  // note any reset output pulse and count resume drive cycles; mon_clr restarts both
  always @(posedge pclk)
  begin
    if (mon_clr)
    begin
      saw_rst <= 1'b0;
      res_cyc <= 0;
    end
    else
    begin
      if (presetn && reset_out === 1'b1)
        saw_rst <= 1'b1;
      if (usb_resume_oe === 1'b1)
        res_cyc <= res_cyc + 1;
    end
  end
  task automatic end_of_test();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic see(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  // n edges, then settle at the falling edge
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // new host line command, launched just after a rising edge
  task automatic set_line(input logic [1:0] m);
    @(posedge pclk);
    line_mode <= m;
  endtask
  // one cycle pulse on the external wake pin
  task automatic pulse_wake();
    @(posedge pclk);
    external_wake_input <= 1'b1;
    @(posedge pclk);
    external_wake_input <= 1'b0;
  endtask
  // restart the reset and resume monitors
  task automatic clr_mon();
    @(posedge pclk);
    mon_clr <= 1'b1;
    @(posedge pclk);
    mon_clr <= 1'b0;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    n = 1;
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      num_errors++;
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, ev);
    see(ev, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, rv, ev);
    cmp(rv, x);
  endtask
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, external_wake_input, feature_en, mon_clr} = 8'h01;
    {paddr, pwdata, line_mode, num_errors, checked} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    mon_clr <= 1'b0;
    tick(1);
    see(reset_out, 1'b0);
    for (int i = 0; i < 20; i += 4)
      rd(12'(i), 32'h0);
    apb(1'b1, `UCR_ADDR_LINE + 12'h004, 32'hffffffff, rv, ev);
    see(ev, 1'b1);
    apb(1'b0, `UCR_ADDR_LINE + 12'h004, 32'h0, rv, ev);
    cmp(rv, 32'h0);
    wr(`UCR_ADDR_CTRL, 32'h3);
    wr(`UCR_ADDR_MASK, 32'hf);
    tick(1);
    see(dp_pullup_oe, 1'b1);
    see(boot_map_normal, 1'b1);
    // bus reset with the scope bit clear, then set
    for (int s = 0; s < 2; s++)
    begin
      wr(`UCR_ADDR_CTRL, 32'h3 | (s << 2));
      clr_mon();
      set_line(2'd2);
      tick(70);
      set_line(2'd0);
      tick(4);
      see(saw_rst, s[0]);
      rd(`UCR_ADDR_STAT, 32'h1);
      rd(`UCR_ADDR_CTRL, 32'h3 | (s << 2));
      rd(`UCR_ADDR_MASK, s ? 32'h0 : 32'hf);
      if (s == 0)
        rd(`UCR_ADDR_VEC, {24'h0, `UCR_VEC_BUSRST});
      see(cpu_irq, !s[0]);
      wr(`UCR_ADDR_STAT, 32'hf);
    end
    // suspend, idle bit, wake by external input, then by bus traffic
    wr(`UCR_ADDR_MASK, 32'ha);
    set_line(2'd1);
    tick(IDLE + 5);
    rd(`UCR_ADDR_STAT, 32'h2);
    see(cpu_irq, 1'b1);
    wr(`UCR_ADDR_PWR, 32'h1);
    tick(2);
    see(clk_enable_out, 1'b0);
    rd(`UCR_ADDR_CTRL, 32'h7);
    pulse_wake();
    tick(4);
    see(clk_enable_out, 1'b1);
    rd(`UCR_ADDR_PWR, 32'h0);
    rd(`UCR_ADDR_VEC, {24'h0, `UCR_VEC_EXTWAKE});
    wr(`UCR_ADDR_MASK, 32'h4);
    wr(`UCR_ADDR_PWR, 32'h1);
    tick(2);
    set_line(2'd0);
    tick(4);
    see(clk_enable_out, 1'b1);
    rd(`UCR_ADDR_PWR, 32'h0);
    rd(`UCR_ADDR_VEC, {24'h0, `UCR_VEC_RESUME});
    wr(`UCR_ADDR_STAT, 32'hf);
    // wake pulse while running leaves the clocks alone
    pulse_wake();
    tick(4);
    see(clk_enable_out, 1'b1);
    rd(`UCR_ADDR_PWR, 32'h0);
    // suspend ignored by firmware gets forced into idle
    wr(`UCR_ADDR_MASK, 32'h0);
    set_line(2'd1);
    tick(IDLE + SMAX + 15);
    see(clk_enable_out, 1'b0);
    rd(`UCR_ADDR_PWR, 32'h1);
    set_line(2'd0);
    wr(`UCR_ADDR_PWR, 32'h0);
    wr(`UCR_ADDR_STAT, 32'hf);
    // remote wake refused until granted, then driven
    set_line(2'd1);
    tick(IDLE + 5);
    wr(`UCR_ADDR_CTRL, 32'hf);
    clr_mon();
    tick(50);
    cmp(32'(res_cyc), 32'h0);
    rd(`UCR_ADDR_LINE, 32'h1);
    @(posedge pclk);
    feature_en <= 1'b1;
    tick(DRV + 15);
    see(res_cyc >= DRV / 2 && res_cyc <= DRV * 15 / 2, 1'b1);
    rd(`UCR_ADDR_CTRL, 32'h7);
    set_line(2'd0);
    feature_en <= 1'b0;
    // master reset in mid-run
    tick(4);
    @(posedge pclk);
    presetn <= 1'b0;
    tick(2);
    see(reset_out, 1'b1);
    see(dp_pullup_oe, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(`UCR_ADDR_CTRL, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire

// File: ucr_chk_properties.sv
// port checker for ucr_ctrl
`timescale 1ns/1ns
`default_nettype none
`include "ucr_consts.svh"
module ucr_chk #(
  parameter int unsigned IDLE_CYC     = 20,
  parameter int unsigned SUSP_MAX_CYC = 200,
  parameter int unsigned RW_WAIT_CYC  = 40,
  parameter int unsigned RW_DRIVE_CYC = 30
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // line state
  input wire logic        usb_line_idle,
  input wire logic        usb_line_se0,
  input wire logic        remote_wake_feature,
  // watched outputs
  input wire logic        dp_pullup_out,
  input wire logic        dp_pullup_oe,
  input wire logic        usb_resume_out,
  input wire logic        usb_resume_oe,
  input wire logic        reset_out,
  input wire logic        cpu_reset_out,
  input wire logic        boot_map_normal,
  input wire logic        clk_enable_out
);
  logic       ctrl_wr;   // finished write to the control register
  logic [6:0] se0_cnt_q; // se0 run length
  logic [9:0] idl_cnt_q; // idle run length
  logic [7:0] drv_cnt_q; // resume drive length
  assign ctrl_wr = psel & penable & pready & pwrite & (paddr == `UCR_ADDR_CTRL);
  // run lengths saturate so a long stretch never wraps back to a small count
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      se0_cnt_q <= 7'h00;
    else
      se0_cnt_q <= !usb_line_se0 ? 7'h00 : se0_cnt_q + 7'(se0_cnt_q != 7'h7f);
  // idle run, cleared by any traffic or se0
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      idl_cnt_q <= 10'h000;
    else
      idl_cnt_q <= !usb_line_idle ? 10'h000 : idl_cnt_q + 10'(idl_cnt_q != 10'h3ff);
  // cycles the resume drive has stood
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      drv_cnt_q <= 8'h00;
    else
      drv_cnt_q <= !usb_resume_oe ? 8'h00 : drv_cnt_q + 8'(drv_cnt_q != 8'hff);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pullup_pair: assert property (dp_pullup_oe == dp_pullup_out)
    else $error("pullup level and enable differ");
  chk_pullup_cause: assert property ($changed(dp_pullup_oe) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("pullup changed without a control write");
  chk_map_cause: assert property ($changed(boot_map_normal) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("memory map changed without a control write");
  chk_rst_cause: assert property ($rose(reset_out) |-> se0_cnt_q >= 7'd62)
    else $error("reset output rose without a long se0");
  chk_cpu_rst_pair: assert property (cpu_reset_out == reset_out)
    else $error("cpu reset and reset output differ");
  chk_resume_pair: assert property (usb_resume_out == usb_resume_oe)
    else $error("resume level and enable differ");
  chk_wake_gate: assert property ($rose(usb_resume_oe) |->
      remote_wake_feature && idl_cnt_q >= IDLE_CYC + RW_WAIT_CYC)
    else $error("remote wake started too early or not granted");
  chk_wake_len: assert property ($fell(usb_resume_oe) |->
      drv_cnt_q >= RW_DRIVE_CYC / 2 && drv_cnt_q <= RW_DRIVE_CYC * 15 / 2)
    else $error("resume drive length out of range");
  chk_forced_idle: assert property (idl_cnt_q == IDLE_CYC + SUSP_MAX_CYC + 8 |-> !clk_enable_out)
    else $error("clocks still running long after suspend");
  chk_ready_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("slave error without ready");
endmodule
bind ucr_ctrl ucr_chk #(.IDLE_CYC(IDLE_CYC), .SUSP_MAX_CYC(SUSP_MAX_CYC),
  .RW_WAIT_CYC(RW_WAIT_CYC), .RW_DRIVE_CYC(RW_DRIVE_CYC)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .usb_line_idle, .usb_line_se0, .remote_wake_feature, .dp_pullup_out, .dp_pullup_oe,
  .usb_resume_out, .usb_resume_oe, .reset_out, .cpu_reset_out, .boot_map_normal,
  .clk_enable_out);
`default_nettype wire

// File: ucr_consts.svh
// offsets, bit positions, reset values and timing counts of the connect/reset/suspend control
`ifndef UCR_CONSTS_SVH
`define UCR_CONSTS_SVH

// register byte addresses
`define UCR_ADDR_CTRL     12'h000
`define UCR_ADDR_STAT     12'h004
`define UCR_ADDR_MASK     12'h008
`define UCR_ADDR_VEC      12'h00c
`define UCR_ADDR_PWR      12'h010
`define UCR_ADDR_LINE     12'h014

// control register fields
`define UCR_CTRL_CONNECT  0
`define UCR_CTRL_SHADOW   1
`define UCR_CTRL_SCOPE    2
`define UCR_CTRL_RWAKE    3

// status / mask register fields
`define UCR_ST_BUSRST     0
`define UCR_ST_SUSPEND    1
`define UCR_ST_RESUME     2
`define UCR_ST_EXTWAKE    3
`define UCR_ST_W          4

// power control and line state fields
`define UCR_PWR_IDLE      0
`define UCR_LINE_SUSP     0
`define UCR_LINE_LOWPWR   1
`define UCR_LINE_DRIVE    2
`define UCR_LINE_FEATURE  3

// reset values
`define UCR_CTRL_RST      4'h0
`define UCR_STAT_RST      4'h0
`define UCR_MASK_RST      4'h0

// interrupt vector codes
`define UCR_VEC_NONE      8'h00
`define UCR_VEC_BUSRST    8'h17
`define UCR_VEC_SUSPEND   8'h18
`define UCR_VEC_RESUME    8'h19
`define UCR_VEC_EXTWAKE   8'h1a

// timing: figures in their own unit, counts at the pclk rate
`define UCR_CLK_MHZ       25
`define UCR_SE0_NS        2500
`define UCR_SE0_CYC       ((`UCR_SE0_NS * `UCR_CLK_MHZ + 999) / 1000)
`define UCR_IDLE_US       3000
`define UCR_IDLE_CYC      (`UCR_IDLE_US * `UCR_CLK_MHZ + 1)
`define UCR_SUSP_MAX_US   10000
`define UCR_SUSP_MAX_CYC  (`UCR_SUSP_MAX_US * `UCR_CLK_MHZ)
`define UCR_RW_WAIT_US    5000
`define UCR_RW_WAIT_CYC   (`UCR_RW_WAIT_US * `UCR_CLK_MHZ)
`define UCR_RW_DRIVE_US   2000
`define UCR_RW_DRIVE_CYC  (`UCR_RW_DRIVE_US * `UCR_CLK_MHZ)
`define UCR_TMR_W         18

`endif

// File: ucr_ctrl.sv
// usb connect, bus reset, suspend/resume and remote wake control with apb registers
// Contract
// - connect bit drives pullup, else tristate
// - connect bit survives bus reset
// - shadow bit selects normal memory map
// - scoped bus reset clears all but three
// - scoped bus reset asserts reset output
// - scope bit survives bus reset
// - bus reset sets status flag
// - masked bus reset interrupts, vector 0x17 (code: only with the scope bit clear; scoped reset clears the mask)
// - idle over 3.0 ms means suspend
// - suspended within 10 ms of detection
// - suspend sets flag and interrupt
// - idle bit stops clocks, state kept
// - bus activity wakes, flags resume (code: clears the idle bit only with the resume mask bit set)
// - resume interrupt clears idle bit
// - external wake restarts clocks, clears idle (code: only with the external wake mask bit set)
// - without idle bit clocks keep running
// - remote wake bit drives resume upstream
// - remote wake only when host enabled
// - remote wake after 5 ms suspended
// - resume signalling lasts 1 to 15 ms
// - master reset asserts reset output
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ucr_consts.svh"
module ucr_ctrl #(
  parameter int unsigned IDLE_CYC     = `UCR_IDLE_CYC,
  parameter int unsigned SUSP_MAX_CYC = `UCR_SUSP_MAX_CYC,
  parameter int unsigned RW_WAIT_CYC  = `UCR_RW_WAIT_CYC,
  parameter int unsigned RW_DRIVE_CYC = `UCR_RW_DRIVE_CYC
) (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // usb line state from the transceiver
  input  wire logic        usb_line_idle,
  input  wire logic        usb_line_se0,
  input  wire logic        remote_wake_feature,
  // external wake
  input  wire logic        external_wake_input,
  // usb pins
  output logic             dp_pullup_out,
  output logic             dp_pullup_oe,
  output logic             usb_resume_out,
  output logic             usb_resume_oe,
  // system
  output logic             reset_out,
  output logic             cpu_reset_out,
  output logic             boot_map_normal,
  output logic             clk_enable_out,
  output logic             cpu_irq
);
  // control bits and state
  logic [3:0]              ctrl_q;      // connect, shadow, scope, remote wake request
  logic [`UCR_ST_W-1:0]    stat_q;      // sticky event flags
  logic [`UCR_ST_W-1:0]    mask_q;      // interrupt enables
  logic                    idle_q;      // idle request bit
  logic                    susp_q;      // bus is in suspend
  logic                    ext_q;       // external wake, previous sample
  logic                    se0_done_q;  // bus reset seen, previous cycle
  logic                    idle_done_q; // idle timeout, previous cycle
  ucr_pkg::ucr_rw_state_t  rw_q;        // remote wake sequencer
  // timer flags
  logic                    se0_done;
  logic                    idle_done;
  logic                    susp_max_done;
  logic                    rw_wait_done;
  logic                    drive_done;
  // events and decode
  logic                    bus_rst_evt;
  logic                    soft_clr;
  logic                    susp_evt;
  logic                    resume_evt;
  logic                    ext_evt;
  logic                    setup;
  logic                    wr;
  logic                    mapped;
  logic [`UCR_ST_W-1:0]    set_v;
  logic [`UCR_ST_W-1:0]    pend;
  logic [31:0]             rd_v;
  logic [7:0]              vec_v;

  // bus reset: se0 held for the minimum reset time
  ucr_timer #(.LIMIT(`UCR_SE0_CYC)) u_se0 (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (usb_line_se0),
    .done    (se0_done)
  );

  // suspend detect: idle line timer, restarted by any activity
  ucr_timer #(.LIMIT(IDLE_CYC)) u_idle (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (usb_line_idle),
    .done    (idle_done)
  );

  // age of the suspend, upper bound for entering low power; two cycles short
  // so that the idle bit and then the clock gate both land by the deadline
  ucr_timer #(.LIMIT(SUSP_MAX_CYC - 2)) u_smax (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (susp_q),
    .done    (susp_max_done)
  );

  // age of the suspend, lower bound before remote wake
  ucr_timer #(.LIMIT(RW_WAIT_CYC)) u_rwait (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (susp_q),
    .done    (rw_wait_done)
  );

  // length of the upstream resume signalling
  ucr_timer #(.LIMIT(RW_DRIVE_CYC)) u_drive (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (rw_q == ucr_pkg::UCR_RW_DRIVE),
    .done    (drive_done)
  );

  // rising edges of the detectors, resume from the line level while suspended; pclk is free running, never gated,
  // so all wake sensing works while the core clocks are stopped
  // ungated wake sensing
  assign bus_rst_evt = se0_done & ~se0_done_q;
  assign susp_evt    = idle_done & ~idle_done_q & ~susp_q;
  assign resume_evt  = susp_q & ~usb_line_idle & (rw_q != ucr_pkg::UCR_RW_DRIVE);
  assign ext_evt     = external_wake_input & ~ext_q;

  // scoped bus reset: clears everything but connect, shadow, scope and the bus reset flag
  // scoped logic clear
  assign soft_clr = bus_rst_evt & ctrl_q[`UCR_CTRL_SCOPE];

  // apb decode: setup phase latches the answer, access phase completes
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pready & pwrite & ~pslverr;
  assign mapped = (paddr == `UCR_ADDR_CTRL) | (paddr == `UCR_ADDR_STAT) |
                  (paddr == `UCR_ADDR_MASK) | (paddr == `UCR_ADDR_VEC) |
                  (paddr == `UCR_ADDR_PWR)  | (paddr == `UCR_ADDR_LINE);

  // hardware set terms of the status flags
  always_comb
  begin
    set_v = '0;
    set_v[`UCR_ST_BUSRST]  = bus_rst_evt;
    set_v[`UCR_ST_SUSPEND] = susp_evt;
    set_v[`UCR_ST_RESUME]  = resume_evt;
    set_v[`UCR_ST_EXTWAKE] = ext_evt;
  end

  assign pend = stat_q & mask_q;

  // vector of the highest priority pending source, bus reset first
  always_comb
  begin
    if (pend[`UCR_ST_BUSRST])
      vec_v = `UCR_VEC_BUSRST;
    else if (pend[`UCR_ST_RESUME])
      vec_v = `UCR_VEC_RESUME;
    else if (pend[`UCR_ST_EXTWAKE])
      vec_v = `UCR_VEC_EXTWAKE;
    else if (pend[`UCR_ST_SUSPEND])
      vec_v = `UCR_VEC_SUSPEND;
    else
      vec_v = `UCR_VEC_NONE;
  end

  // read mux; unused upper bits read as zero
  always_comb
  begin
    rd_v = 32'h0000_0000;
    case (paddr)
      `UCR_ADDR_CTRL: rd_v[3:0] = ctrl_q;
      `UCR_ADDR_STAT: rd_v[`UCR_ST_W-1:0] = stat_q;
      `UCR_ADDR_MASK: rd_v[`UCR_ST_W-1:0] = mask_q;
      `UCR_ADDR_VEC:  rd_v[7:0] = vec_v;
      `UCR_ADDR_PWR:  rd_v[`UCR_PWR_IDLE] = idle_q;
      `UCR_ADDR_LINE:
      begin
        rd_v[`UCR_LINE_SUSP]    = susp_q;
        rd_v[`UCR_LINE_LOWPWR]  = idle_q;
        rd_v[`UCR_LINE_DRIVE]   = (rw_q == ucr_pkg::UCR_RW_DRIVE);
        rd_v[`UCR_LINE_FEATURE] = remote_wake_feature;
      end
      default:        rd_v = 32'h0000_0000;
    endcase
  end

  // apb answer: no wait states, error on unmapped addresses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (setup)
    begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= pwrite ? 32'h0000_0000 : rd_v;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // edge detector history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      se0_done_q  <= 1'b0;
      idle_done_q <= 1'b0;
      ext_q       <= 1'b0;
    end
    else
    begin
      se0_done_q  <= se0_done;
      idle_done_q <= idle_done;
      ext_q       <= external_wake_input;
    end
  end

  // control register; connect, shadow and scope ignore bus reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= `UCR_CTRL_RST;
    else
    begin
      if (wr && paddr == `UCR_ADDR_CTRL)
        ctrl_q <= pwdata[3:0];
      if (soft_clr)
        ctrl_q[`UCR_CTRL_RWAKE] <= 1'b0;
      // request is consumed once the resume signalling has ended
      if (rw_q == ucr_pkg::UCR_RW_DRIVE && drive_done)
        ctrl_q[`UCR_CTRL_RWAKE] <= 1'b0;
    end
  end

  // status flags: write one to clear, a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= `UCR_STAT_RST;
    else if (soft_clr)
      stat_q <= set_v;
    else if (wr && paddr == `UCR_ADDR_STAT)
      stat_q <= (stat_q & ~pwdata[`UCR_ST_W-1:0]) | set_v;
    else
      stat_q <= stat_q | set_v;
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_q <= `UCR_MASK_RST;
    else if (soft_clr)
      mask_q <= `UCR_MASK_RST;
    else if (wr && paddr == `UCR_ADDR_MASK)
      mask_q <= pwdata[`UCR_ST_W-1:0];
  end

  // idle bit: set by firmware, cleared by the wake interrupts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle_q <= 1'b0;
    else if (soft_clr)
      idle_q <= 1'b0;
    else if ((resume_evt & mask_q[`UCR_ST_RESUME]) |
             (ext_evt & mask_q[`UCR_ST_EXTWAKE]))
      idle_q <= 1'b0;
    else if (wr && paddr == `UCR_ADDR_PWR)
      idle_q <= pwdata[`UCR_PWR_IDLE];
    // firmware too slow: force the low power state before the deadline
    // suspend deadline
    else if (susp_q && susp_max_done)
      idle_q <= 1'b1;
  end

  // suspend state of the bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      susp_q <= 1'b0;
    else if (soft_clr || resume_evt || bus_rst_evt)
      susp_q <= 1'b0;
    else if (susp_evt)
      susp_q <= 1'b1;
    else if (rw_q == ucr_pkg::UCR_RW_DRIVE && drive_done)
      susp_q <= 1'b0;
  end

  // remote wake sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rw_q <= ucr_pkg::UCR_RW_IDLE;
    else if (soft_clr)
      rw_q <= ucr_pkg::UCR_RW_IDLE;
    else
    begin
      case (rw_q)
        ucr_pkg::UCR_RW_IDLE:
          if (ctrl_q[`UCR_CTRL_RWAKE] && remote_wake_feature && susp_q)
            rw_q <= ucr_pkg::UCR_RW_WAIT;
        ucr_pkg::UCR_RW_WAIT:
          if (!susp_q || !ctrl_q[`UCR_CTRL_RWAKE])
            rw_q <= ucr_pkg::UCR_RW_IDLE;
          else if (rw_wait_done)
            rw_q <= ucr_pkg::UCR_RW_DRIVE;
        ucr_pkg::UCR_RW_DRIVE:
          if (drive_done)
            rw_q <= ucr_pkg::UCR_RW_IDLE;
        default:
          rw_q <= ucr_pkg::UCR_RW_IDLE;
      endcase
    end
  end

  // pins, clock gate, interrupt: every output from a flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dp_pullup_out   <= 1'b0;
      dp_pullup_oe    <= 1'b0;
      usb_resume_out  <= 1'b0;
      usb_resume_oe   <= 1'b0;
      boot_map_normal <= 1'b0;
      clk_enable_out  <= 1'b1;
      cpu_irq         <= 1'b0;
    end
    else
    begin
      dp_pullup_out   <= ctrl_q[`UCR_CTRL_CONNECT];
      dp_pullup_oe    <= ctrl_q[`UCR_CTRL_CONNECT];
      usb_resume_out  <= (rw_q == ucr_pkg::UCR_RW_DRIVE);
      usb_resume_oe   <= (rw_q == ucr_pkg::UCR_RW_DRIVE);
      boot_map_normal <= ctrl_q[`UCR_CTRL_SHADOW];
      clk_enable_out  <= ~idle_q;
      cpu_irq         <= |pend;
    end
  end

  // reset outputs: high through master reset, and during scoped bus reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_out     <= 1'b1;
      cpu_reset_out <= 1'b1;
    end
    else
    begin
      reset_out     <= se0_done & ctrl_q[`UCR_CTRL_SCOPE];
      cpu_reset_out <= se0_done & ctrl_q[`UCR_CTRL_SCOPE];
    end
  end
endmodule
`default_nettype wire

// File: ucr_host_model.sv
// upstream host model driving the usb line state
`timescale 1ns/1ns
`default_nettype none
module ucr_host_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench command: 0 traffic, 1 idle, 2 bus reset
  input  wire logic [1:0] line_mode,
  input  wire logic       feature_en,
  // line state seen by the device
  output logic            usb_line_idle,
  output logic            usb_line_se0,
  output logic            remote_wake_feature
);
  logic toggle_q; // traffic flips j and k each cycle, never a long idle
  // host holds idle, sends traffic or drives se0
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      toggle_q      <= 1'b0;
      usb_line_idle <= 1'b0;
      usb_line_se0  <= 1'b0;
    end
    else
    begin
      toggle_q      <= ~toggle_q;
      usb_line_idle <= (line_mode == 2'd1) || (line_mode == 2'd0 && toggle_q);
      usb_line_se0  <= (line_mode == 2'd2);
    end
  // remote wake only once the host granted it
  assign remote_wake_feature = feature_en;
endmodule
`default_nettype wire

// File: ucr_pkg.sv
// types of the connect/reset/suspend control
`default_nettype none
package ucr_pkg;
  // remote wake sequencer states
  typedef enum logic [1:0] {
    UCR_RW_IDLE,
    UCR_RW_WAIT,
    UCR_RW_DRIVE
  } ucr_rw_state_t;
endpackage
`default_nettype wire

// File: ucr_timer.sv
// cycle timer: flags once its enable has held for LIMIT cycles
`timescale 1ns/1ns
`default_nettype none
`include "ucr_consts.svh"
module ucr_timer #(
  parameter int unsigned LIMIT = 1
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic run,
  // status
  output logic      done
);
  // terminal count, one below the limit since done is registered
  localparam logic [`UCR_TMR_W-1:0] LAST = `UCR_TMR_W'(LIMIT - 1);

  logic [`UCR_TMR_W-1:0] cnt_q;  // elapsed cycles of run

  // count while run holds, restart whenever it drops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      done  <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= '0;
      done  <= 1'b0;
    end
    else if (cnt_q == LAST)
      done <= 1'b1;  // saturate; stays up until run drops
    else
      cnt_q <= cnt_q + 1'b1;
  end
endmodule
`default_nettype wire
